// ---- core/bcd_time_counter.sv ----
// Purpose: internal bcd time and calendar counters
// Assumes: tick is one pulse per second, load wins over tick
// Notes:   leap years every fourth year, good through 2099
`timescale 1ns/1ps
`default_nettype none
module bcd_time_counter
   import rtc_pkg::*;
(
   input  wire logic   core_clk,
   input  wire logic   rstn,
   time_link_if.counter tl
);
   // one bcd step: returns {wrapped, next}; out-of-range values wrap too
   function automatic logic [8:0] bcd_step(input logic [7:0] v,
                                           input logic [7:0] last,
                                           input logic [7:0] first);
      if (v >= last) return {1'b1, first};
      else if (v[3:0] >= 4'h9) return {1'b0, v[7:4] + 4'h1, 4'h0};
      else return {1'b0, v[7:4], v[3:0] + 4'h1};
   endfunction

   // last day of a month in bcd
   function automatic logic [7:0] month_last(input logic [7:0] mon,
                                             input logic [7:0] yr);
      logic leap;
      leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                   : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
      case (mon)
         8'h02:                      return leap ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
         default:                    return 8'h31;
      endcase
   endfunction

   rtc_time_s cnt_r;
   rtc_time_s cnt_nxt;

   // ripple carry through the calendar
   always_comb begin
      logic [8:0] s;
      logic [8:0] m;
      logic [8:0] h;
      logic [8:0] w;
      logic [8:0] d;
      logic [8:0] mo;
      logic [8:0] y;
      s  = bcd_step(cnt_r.sec, 8'h59, 8'h00);
      m  = bcd_step(cnt_r.min, 8'h59, 8'h00);
      h  = bcd_step(cnt_r.hour, 8'h23, 8'h00);
      w  = bcd_step(cnt_r.wday, 8'h07, 8'h01);
      d  = bcd_step(cnt_r.mday, month_last(cnt_r.month, cnt_r.year), 8'h01);
      mo = bcd_step(cnt_r.month, 8'h12, 8'h01);
      y  = bcd_step(cnt_r.year, 8'h99, 8'h00);
      cnt_nxt = cnt_r;
      cnt_nxt.sec = s[7:0];
      if (s[8]) begin
         cnt_nxt.min = m[7:0];
         if (m[8]) begin
            cnt_nxt.hour = h[7:0];
            if (h[8]) begin
               cnt_nxt.wday = w[7:0];
               cnt_nxt.mday = d[7:0];
               if (d[8]) begin
                  cnt_nxt.month = mo[7:0];
                  if (mo[8]) begin
                     cnt_nxt.year = y[7:0];
                  end
               end
            end
         end
      end
   end

   // host load replaces the count outright
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         cnt_r <= TIME_RESET;
      end else if (tl.load) begin
         cnt_r <= tl.load_val;
      end else if (tl.tick) begin
         cnt_r <= cnt_nxt;
      end
   end

   assign tl.now = cnt_r;
endmodule
`default_nettype wire

// ---- core/byte_store.sv ----
// Purpose: plain read/write byte storage below the clock registers
// Assumes: write strobe already qualified by the caller
// Notes:   combinational read so the caller can register the data once
`timescale 1ns/1ps
`default_nettype none
module byte_store
   import rtc_pkg::*;
#(
   parameter int DEPTH = 2040
) (
   input  wire logic              core_clk,
   input  wire logic              wr_en,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [7:0]        wdata,
   output logic      [7:0]        rdata
);
   if (DEPTH < 1 || DEPTH > (1 << ADDR_W)) begin : g_chk
      $error("byte_store depth out of range");
   end

   logic [7:0] mem [DEPTH];

   // contents survive reset, as battery backed storage would
   always_ff @(posedge core_clk) begin
      if (wr_en && int'(addr) < DEPTH) begin
         mem[addr] <= wdata;
      end
   end

   assign rdata = (int'(addr) < DEPTH) ? mem[addr] : 8'h00;
endmodule
`default_nettype wire

// ---- core/bytewide_bcd_rtc_registers.sv ----
// Purpose: byte-wide ram space whose top eight bytes are a bcd clock
// Assumes: bus pins already synchronous to core_clk; a write is a level
// Notes:   read data and drive enable appear one clock after the pins
//          a write is taken at every edge it is seen, last value wins
//          ram contents have no reset; clock state resets to a fixed date
//
// How it works
// - 2k byte space; top eight addresses 7f8..7ff are clock registers.
// - clock registers use the same read and write cycles as ram.
// - time and date kept in bcd, hours in 24-hour form.
// - month lengths and leap years roll the date automatically, through 2099.
// - user registers are a buffered copy; counters never stop for accesses.
// - control bit 6 set stops copying counters into user registers.
// - during that halt user registers keep the snapshot; counters keep running.
// - clearing bit 6 refreshes all user registers together within a second.
// - control bit 7 set freezes updates so the host can load time.
// - clearing bit 7 loads host values into the counters, which kept counting through the hold.
// - seconds bit 7 stops the timebase when 1, runs it when 0.
// - weekday bit 6 makes seconds bit 0 toggle at 512 Hz while the timebase runs.
// - a steady seconds read then shows data bit 0 toggling at 512 Hz.
// - power fail deselects: no reads, no writes, data lines floated.
// - read while chip select low and write strobe high; drive needs output enable.
// - write while chip select and write strobe both low, address steady.
`timescale 1ns/1ps
`default_nettype none
module bytewide_bcd_rtc_registers
   import rtc_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES
) (
   input  wire logic              core_clk,
   input  wire logic              rstn,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic              chip_sel_n,
   input  wire logic              out_drive_n,
   input  wire logic              write_n,
   input  wire logic [7:0]        data_in,
   output logic      [7:0]        data_out,
   output logic                   data_oe,
   input  wire logic              power_fail_threshold
);
   if (TICK_CYC < 2) begin : g_chk
      $error("tick divider must be at least two cycles");
   end

   // the test wave toggles on every base tick, so two ticks per period
   if (TICKS_PER_SEC != 2 * TEST_HZ) begin : g_rate
      $error("base tick rate must be twice the test rate");
   end

   localparam int PW = $clog2(TICK_CYC);
   localparam int SW = $clog2(TICKS_PER_SEC);
   localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYC - 1);
   localparam logic [SW-1:0] SUB_LAST = SW'(TICKS_PER_SEC - 1);

   time_link_if tl ();

   // bus decode; power fail blocks both directions
   // pins are levels sampled each edge, so a held write simply repeats
   logic bus_rd;
   logic bus_wr;
   logic clk_space;
   logic ram_wr;
   logic [7:0] ram_rdata;

   assign clk_space = (addr >= ADDR_CONTROL);
   assign bus_rd    = !chip_sel_n && write_n && !power_fail_threshold;
   assign bus_wr    = !chip_sel_n && !write_n && !power_fail_threshold;
   assign ram_wr    = bus_wr && !clk_space;

   byte_store #(
      .DEPTH (int'(ADDR_CONTROL))
   ) u_store (
      .core_clk (core_clk),
      .wr_en    (ram_wr),
      .addr     (addr),
      .wdata    (data_in),
      .rdata    (ram_rdata)
   );

   bcd_time_counter u_count (
      .core_clk (core_clk),
      .rstn     (rstn),
      .tl       (tl)
   );

   // control and mode bits
   logic      write_hold_r;
   logic      read_halt_r;
   logic      timebase_halt_r;
   logic      test_tick_enable_r;
   logic      load_r;
   rtc_time_s user_r;

   // register write strobes for the control and mode bits below; the user copy decodes its own
   logic wr_ctrl;
   logic wr_sec;
   logic wr_wday;

   assign wr_ctrl = bus_wr && addr == ADDR_CONTROL;
   assign wr_sec  = bus_wr && addr == ADDR_SECONDS;
   assign wr_wday = bus_wr && addr == ADDR_WEEKDAY;

   // write hold: host owns it, nothing else clears it
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         write_hold_r <= 1'b0;
      end else if (wr_ctrl) begin
         write_hold_r <= data_in[CTRL_WRITE_BIT];
      end
   end

   // read halt: freezes the user copy while set
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         read_halt_r <= 1'b0;
      end else if (wr_ctrl) begin
         read_halt_r <= data_in[CTRL_READ_BIT];
      end
   end

   // timebase stop takes effect at once, not gated by write hold
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         timebase_halt_r <= 1'b0;
      end else if (wr_sec) begin
         timebase_halt_r <= data_in[SEC_STOP_BIT];
      end
   end

   // test wave select
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         test_tick_enable_r <= 1'b0;
      end else if (wr_wday) begin
         test_tick_enable_r <= data_in[DAY_TEST_BIT];
      end
   end

   // write hold falling by a host write asks for a counter load
   logic load_req;

   assign load_req = write_hold_r && wr_ctrl && !data_in[CTRL_WRITE_BIT];

   // one-cycle load pulse, so the user copy is stable while it is taken
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         load_r <= 1'b0;
      end else begin
         load_r <= load_req;
      end
   end

   assign tl.load     = load_r;
   assign tl.load_val = user_r;

   // timebase: base ticks at twice the test rate, seconds from 1024 of them
   logic [PW-1:0] pre_r;
   logic [SW-1:0] sub_r;
   logic          base_tick;
   logic          sec_tick_r;
   logic          test_phase_r;

   assign base_tick = !timebase_halt_r && pre_r == PRE_LAST;

   // a stopped timebase freezes the prescaler too, so no partial second leaks
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         pre_r <= '0;
      end else if (!timebase_halt_r) begin
         pre_r <= (pre_r == PRE_LAST) ? '0 : pre_r + 1'b1;
      end
   end

   // base ticks counted within the second
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         sub_r <= '0;
      end else if (base_tick) begin
         sub_r <= (sub_r == SUB_LAST) ? '0 : sub_r + 1'b1;
      end
   end

   // registered second pulse; one cycle late costs no accuracy
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         sec_tick_r <= 1'b0;
      end else begin
         sec_tick_r <= base_tick && sub_r == SUB_LAST;
      end
   end

   // test square wave: one toggle per base tick gives 512 Hz
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         test_phase_r <= 1'b0;
      end else if (base_tick) begin
         test_phase_r <= !test_phase_r;
      end
   end

   // loading the counters swallows that cycle's tick; at most one second lost
   assign tl.tick = sec_tick_r;

   // user copy: follows counters unless halted, held, or just loaded
   // host writes land here first; the load pulse carries them on
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         user_r <= TIME_RESET;
      end else if (bus_wr && clk_space) begin
         case (addr)
            ADDR_SECONDS: begin
               user_r.sec <= data_in & SEC_MASK;
            end
            ADDR_MINUTES: begin
               user_r.min <= data_in & MIN_MASK;
            end
            ADDR_HOURS: begin
               user_r.hour <= data_in & HOUR_MASK;
            end
            ADDR_WEEKDAY: begin
               user_r.wday <= data_in & WDAY_MASK;
            end
            ADDR_MDAY: begin
               user_r.mday <= data_in & MDAY_MASK;
            end
            ADDR_MONTH: begin
               user_r.month <= data_in & MONTH_MASK;
            end
            ADDR_YEAR: begin
               user_r.year <= data_in & YEAR_MASK;
            end
            default: ;
         endcase
      end else if (!read_halt_r && !write_hold_r && !load_r) begin
         user_r <= tl.now;
      end
   end

   // read mux for the clock registers
   logic [7:0] clk_rdata;

   always_comb begin
      case (addr)
         ADDR_CONTROL: begin
            clk_rdata = {write_hold_r, read_halt_r, 6'h00};
         end
         ADDR_SECONDS: begin
            clk_rdata = {timebase_halt_r, user_r.sec[6:1],
                         test_tick_enable_r ? test_phase_r : user_r.sec[0]};
         end
         ADDR_MINUTES: begin
            clk_rdata = user_r.min;
         end
         ADDR_HOURS: begin
            clk_rdata = user_r.hour;
         end
         ADDR_WEEKDAY: begin
            clk_rdata = {1'b0, test_tick_enable_r, 6'h00} | user_r.wday;
         end
         ADDR_MDAY: begin
            clk_rdata = user_r.mday;
         end
         ADDR_MONTH: begin
            clk_rdata = user_r.month;
         end
         ADDR_YEAR: begin
            clk_rdata = user_r.year;
         end
         default:      clk_rdata = 8'h00;
      endcase
   end

   // a read is driven only with output drive low
   logic rd_drive;

   assign rd_drive = bus_rd && !out_drive_n;

   // drive enable, one clock behind the pins
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         data_oe <= 1'b0;
      end else begin
         data_oe <= rd_drive;
      end
   end

   // data held at zero while not driving, so nothing stale leaks out
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         data_out <= 8'h00;
      end else if (rd_drive) begin
         data_out <= clk_space ? clk_rdata : ram_rdata;
      end else begin
         data_out <= 8'h00;
      end
   end
endmodule
`default_nettype wire

// ---- core/rtc_pkg.sv ----
// Purpose: shared constants and types for the byte-wide bcd clock block
// Assumes: 40 MHz core clock, 2k x 8 address space
// Notes:   clock registers sit in the eight top locations
package rtc_pkg;
   localparam int          ADDR_W        = 11;
   localparam int          DATA_W        = 8;
   localparam int          CLK_HZ        = 40_000_000;
   localparam int          TEST_HZ       = 512;
   // base tick toggles the test bit, so it runs at twice the test rate
   localparam int          TICKS_PER_SEC = 2 * TEST_HZ;
   localparam int          TICK_CYCLES   = CLK_HZ / TICKS_PER_SEC;

   localparam logic [10:0] ADDR_CONTROL  = 11'h7f8;
   localparam logic [10:0] ADDR_SECONDS  = 11'h7f9;
   localparam logic [10:0] ADDR_MINUTES  = 11'h7fa;
   localparam logic [10:0] ADDR_HOURS    = 11'h7fb;
   localparam logic [10:0] ADDR_WEEKDAY  = 11'h7fc;
   localparam logic [10:0] ADDR_MDAY     = 11'h7fd;
   localparam logic [10:0] ADDR_MONTH    = 11'h7fe;
   localparam logic [10:0] ADDR_YEAR     = 11'h7ff;

   localparam int          CTRL_WRITE_BIT = 7;
   localparam int          CTRL_READ_BIT  = 6;
   localparam int          SEC_STOP_BIT   = 7;
   localparam int          DAY_TEST_BIT   = 6;

   localparam logic [7:0]  SEC_MASK   = 8'h7f;
   localparam logic [7:0]  MIN_MASK   = 8'h7f;
   localparam logic [7:0]  HOUR_MASK  = 8'h3f;
   localparam logic [7:0]  WDAY_MASK  = 8'h07;
   localparam logic [7:0]  MDAY_MASK  = 8'h3f;
   localparam logic [7:0]  MONTH_MASK = 8'h1f;
   localparam logic [7:0]  YEAR_MASK  = 8'hff;

   typedef struct packed {
      logic [7:0] year;
      logic [7:0] month;
      logic [7:0] mday;
      logic [7:0] wday;
      logic [7:0] hour;
      logic [7:0] min;
      logic [7:0] sec;
   } rtc_time_s;

   localparam rtc_time_s TIME_RESET = '{year: 8'h00, month: 8'h01, mday: 8'h01,
                                        wday: 8'h01, hour: 8'h00, min: 8'h00,
                                        sec: 8'h00};
endpackage

// ---- core/time_link_if.sv ----
// Purpose: carrier between the register front end and the time counters
// Assumes: single core clock domain
// Notes:   load is a one-cycle pulse, tick a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface time_link_if;
   import rtc_pkg::*;
   rtc_time_s now;        // running count
   rtc_time_s load_val;   // values set by the host
   logic      load;
   logic      tick;
   modport counter (output now, input load_val, input load, input tick);
   modport front   (input now, output load_val, output load, output tick);
endinterface
`default_nettype wire

// ---- sim/bytewide_bcd_rtc_registers_bench.sv ----
// Purpose: register-level tests of the byte-wide clock block
// Assumes: short base tick, one second = 1024 * TICK cycles
// Notes:   expectations from bcd calendar rules, not from the design
`timescale 1ns/1ps
`default_nettype none
module bytewide_bcd_rtc_registers_bench;
   import rtc_pkg::*;
   localparam int TICK = 4;
   localparam int SEC  = 1024 * TICK;
   logic              core_clk = 1'b0;
   logic              rstn = 1'b0;
   logic              power_fail_threshold = 1'b0;
   logic [ADDR_W-1:0] addr;
   logic              chip_sel_n;
   logic              out_drive_n;
   logic              write_n;
   logic [7:0]        data_in;
   logic [7:0]        data_out;
   logic              data_oe;
   logic [7:0]        q;
   logic [7:0]        s0;
   int                fails = 0;
   int                compares = 0;
   int                flips;
   // date, month, year in; date, month, year expected a second later
   logic [7:0]        roll [4][6] = '{'{8'h28, 8'h02, 8'h24, 8'h29, 8'h02, 8'h24},
                                      '{8'h28, 8'h02, 8'h23, 8'h01, 8'h03, 8'h23},
                                      '{8'h30, 8'h04, 8'h25, 8'h01, 8'h05, 8'h25},
                                      '{8'h31, 8'h12, 8'h99, 8'h01, 8'h01, 8'h00}};
   always #12.5 core_clk = ~core_clk;
   bytewide_bcd_rtc_registers #(.TICK_CYC(TICK)) dut (
      .core_clk(core_clk), .rstn(rstn), .addr(addr), .chip_sel_n(chip_sel_n),
      .out_drive_n(out_drive_n), .write_n(write_n), .data_in(data_in),
      .data_out(data_out), .data_oe(data_oe), .power_fail_threshold(power_fail_threshold));
   sram_host host (
      .core_clk(core_clk), .data_out(data_out), .addr(addr), .chip_sel_n(chip_sel_n),
      .out_drive_n(out_drive_n), .write_n(write_n), .data_in(data_in));
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rd_chk(input string what, input logic [10:0] a, input logic [7:0] exp);
      host.rd(a, q);
      check(what, q, exp);
   endtask
   task automatic complete_run;
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // hang guard, well over twice the expected run of about 25200 cycles
   initial begin
      repeat (60000) @(posedge core_clk);
      fails++;
      complete_run;
   end
   // main sequence
   initial begin
      repeat (20) @(posedge core_clk);
      rstn <= 1'b1;
      rd_chk("control", ADDR_CONTROL, 8'h00);
      for (int i = 0; i < 4; i++) rd_chk("calendar", ADDR_WEEKDAY + 11'(i), (i == 3) ? 8'h00 : 8'h01);
      host.wr(11'h000, 8'ha5);
      rd_chk("ram low", 11'h000, 8'ha5);
      @(negedge core_clk);
      check("drive", {7'h0, data_oe}, 8'h01);
      @(posedge core_clk);
      host.wr(11'h7f7, 8'h3c);
      rd_chk("ram top", 11'h7f7, 8'h3c);
      // power fail blocks both directions
      power_fail_threshold <= 1'b1;
      host.wr(11'h000, 8'h00);
      rd_chk("pf read", 11'h000, 8'h00);
      @(negedge core_clk);
      check("pf float", {7'h0, data_oe}, 8'h00);
      @(posedge core_clk);
      power_fail_threshold <= 1'b0;
      rd_chk("pf kept", 11'h000, 8'ha5);
      // month ends, leap and non-leap february, year end
      for (int i = 0; i < 4; i++) begin
         host.wr(ADDR_CONTROL, 8'h80);
         rd_chk("hold", ADDR_CONTROL, 8'h80);
         host.wr(ADDR_SECONDS, 8'h59);
         host.wr(ADDR_MINUTES, 8'h59);
         host.wr(ADDR_HOURS, 8'h23);
         host.wr(ADDR_WEEKDAY, 8'h07);
         for (int j = 0; j < 3; j++) host.wr(ADDR_MDAY + 11'(j), roll[i][j]);
         host.wr(ADDR_CONTROL, 8'h00);
         host.idle(SEC + 64);
         rd_chk("minutes", ADDR_MINUTES, 8'h00);
         rd_chk("hours", ADDR_HOURS, 8'h00);
         rd_chk("weekday", ADDR_WEEKDAY, 8'h01);
         for (int j = 0; j < 3; j++) rd_chk("date", ADDR_MDAY + 11'(j), roll[i][j + 3]);
      end
      // read halt freezes the copy, counting goes on
      host.wr(ADDR_CONTROL, 8'h40);
      rd_chk("halt", ADDR_CONTROL, 8'h40);
      host.rd(ADDR_SECONDS, s0);
      host.idle(SEC + 64);
      rd_chk("frozen", ADDR_SECONDS, s0);
      host.wr(ADDR_CONTROL, 8'h00);
      host.idle(2);
      host.rd(ADDR_SECONDS, q);
      check("refresh", {7'h0, q !== s0}, 8'h01);
      // stopped timebase keeps seconds
      host.wr(ADDR_CONTROL, 8'h80);
      host.wr(ADDR_SECONDS, 8'h90);
      host.wr(ADDR_CONTROL, 8'h00);
      host.idle(SEC + 64);
      rd_chk("stopped", ADDR_SECONDS, 8'h90);
      // test mode: bit 0 flips every TICK cycles
      host.wr(ADDR_CONTROL, 8'h80);
      host.wr(ADDR_SECONDS, 8'h00);
      host.wr(ADDR_WEEKDAY, 8'h41);
      host.wr(ADDR_CONTROL, 8'h00);
      host.idle(4);
      host.watch(16 * TICK, flips);
      // one toggle per base tick: 16 * TICK cycles give exactly 16 flips
      check("test flips", 8'(flips), 8'h10);
      host.idle(2);
      complete_run;
   end
endmodule
`default_nettype wire

// ---- sim/rtc_bus_chk.sv ----
// Purpose: pin-level assertions for the byte-wide clock block
// Assumes: one clock domain, synchronous active-low reset
// Notes:   test and stop flags mirrored from host writes only
`timescale 1ns/1ps
`default_nettype none
module rtc_bus_chk
   import rtc_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES
) (
   input wire logic              core_clk,
   input wire logic              rstn,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic              chip_sel_n,
   input wire logic              out_drive_n,
   input wire logic              write_n,
   input wire logic [7:0]        data_in,
   input wire logic [7:0]        data_out,
   input wire logic              data_oe,
   input wire logic              power_fail_threshold
);
   logic        rd_ok;
   logic        wr_ok;
   logic        test_r;
   logic        stop_r;
   logic        valid_r;
   logic        bval_r;
   logic        bit_r;
   logic [15:0] flat_r;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // decoded bus cycles
   assign rd_ok = !chip_sel_n && write_n && !out_drive_n && !power_fail_threshold;
   assign wr_ok = !chip_sel_n && !write_n && !power_fail_threshold;
   // flags follow writes at once, as the design's do; neither is gated by write hold
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         test_r <= 1'b0;
         stop_r <= 1'b0;
      end else if (wr_ok && addr == ADDR_WEEKDAY) begin
         test_r <= data_in[DAY_TEST_BIT];
      end else if (wr_ok && addr == ADDR_SECONDS) begin
         stop_r <= data_in[SEC_STOP_BIT];
      end
   end
   // count cycles that seconds bit 0 sits still during a steady read
   always_ff @(posedge core_clk) begin
      valid_r <= rd_ok && addr == ADDR_SECONDS;
      bval_r  <= valid_r;
      bit_r   <= data_out[0];
      if (valid_r && bval_r && data_out[0] == bit_r && test_r && !stop_r) begin
         flat_r <= flat_r + 16'h1;
      end else begin
         flat_r <= 16'h0;
      end
   end
   cs_off_float_a: assert property (chip_sel_n |=> !data_oe)
      else $error("data driven while deselected");
   oe_off_float_a: assert property (out_drive_n |=> !data_oe)
      else $error("data driven with output drive off");
   pf_float_a: assert property (power_fail_threshold |=> !data_oe)
      else $error("data driven during power fail");
   read_drive_a: assert property (rd_ok |=> data_oe)
      else $error("read not driven one cycle later");
   write_float_a: assert property (!chip_sel_n && !write_n |=> !data_oe)
      else $error("data driven during write");
   idle_zero_a: assert property (!data_oe |-> data_out == 8'h00)
      else $error("data out not zero while undriven");
   ctrl_low_zero_a: assert property (rd_ok && addr == ADDR_CONTROL |=> data_out[5:0] == 6'h00)
      else $error("control unused bits not zero");
   ram_echo_a: assert property ((wr_ok && addr < ADDR_CONTROL) ##1 (rd_ok && $stable(addr))
      |=> data_out == $past(data_in, 2))
      else $error("ram byte not returned");
   test_toggle_a: assert property (flat_r <= TICK_CYC)
      else $error("seconds bit 0 not toggling in test mode");
endmodule
bind bytewide_bcd_rtc_registers rtc_bus_chk #(.TICK_CYC(TICK_CYC)) chk (
   .core_clk(core_clk), .rstn(rstn), .addr(addr), .chip_sel_n(chip_sel_n),
   .out_drive_n(out_drive_n), .write_n(write_n), .data_in(data_in),
   .data_out(data_out), .data_oe(data_oe), .power_fail_threshold(power_fail_threshold));
`default_nettype wire

// ---- sim/sram_host.sv ----
// Purpose: host on the asynchronous ram bus, as bus tasks
// Assumes: every task is entered just after a rising edge
// Notes:   tasks leave pins asserted; idle releases them
`timescale 1ns/1ps
`default_nettype none
module sram_host
   import rtc_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic [7:0]        data_out,
   output var  logic [ADDR_W-1:0] addr,
   output var  logic              chip_sel_n,
   output var  logic              out_drive_n,
   output var  logic              write_n,
   output var  logic [7:0]        data_in
);
   // idle bus at time zero
   initial begin
      addr = '0;
      chip_sel_n = 1'b1;
      out_drive_n = 1'b1;
      write_n = 1'b1;
      data_in = 8'h00;
   end
   // one write cycle; caller passes zero in unused clock bits
   task automatic wr(input logic [10:0] a, input logic [7:0] d);
      addr <= a;
      data_in <= d;
      chip_sel_n <= 1'b0;
      write_n <= 1'b0;
      out_drive_n <= 1'b1;
      @(posedge core_clk);
   endtask
   // read held two edges; write data lines no longer hold the old byte
   task automatic rd(input logic [10:0] a, output logic [7:0] q);
      addr <= a;
      data_in <= ~data_in;
      chip_sel_n <= 1'b0;
      write_n <= 1'b1;
      out_drive_n <= 1'b0;
      @(posedge core_clk);
      @(negedge core_clk);
      q = data_out;
      @(posedge core_clk);
   endtask
   // steady seconds read counting bit 0 flips
   task automatic watch(input int n, output int flips);
      logic [7:0] q0;
      logic       pb;
      rd(ADDR_SECONDS, q0);
      pb = q0[0];
      flips = 0;
      repeat (n) begin
         @(negedge core_clk);
         if (data_out[0] !== pb) flips++;
         pb = data_out[0];
         @(posedge core_clk);
      end
   endtask
   // release bus and wait
   task automatic idle(input int n);
      chip_sel_n <= 1'b1;
      write_n <= 1'b1;
      out_drive_n <= 1'b1;
      repeat (n) @(posedge core_clk);
   endtask
endmodule
`default_nettype wire
